//--- design/bit_sync.sv
// Two-stage level synchroniser.
`timescale 1ns/1ns
module bit_sync (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // Level in and out.
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_ff;

  // The first stage feeds only the second one.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      meta_ff <= 1'b0;
      o_q     <= 1'b0;
    end else begin
      meta_ff <= i_d;
      o_q     <= meta_ff;
    end
  end
endmodule

//--- design/flash_cmd_device.sv
// Device end: frames commands on the serial clock and reports them to the core.
//
// Functional notes
// (RULE1) Serial clock modes 0 and 3 only.
// (RULE2) Either idle clock level is accepted.
// (RULE3) Sample rising edge, drive falling edge.
// (RULE4) Dual program: output pin becomes second input.
// (RULE5) Dual read: input pin becomes second output.
// (RULE6) Host asserts chip select to start.
// (RULE7) Opcode of eight bits comes first.
// (RULE8) All bytes move most-significant bit first.
// (RULE9) Chip select deassertion ends the command.
// (RULE10) Unsupported opcode starts no operation.
// (RULE11) After bad opcode, ignore input until reselect.
// (RULE12) Early deselect: do nothing, return idle.
// (RULE13) Address is three bytes, bits 23..0.
// (RULE14) Upper two address bits are ignored.
// (RULE15) Deselect clears bit counter and decoder.
`timescale 1ns/1ns
module flash_cmd_device (
  // Link side.
  spi_flash_if.device           link,
  // Core side, on the serial clock domain.
  input  wire logic             i_rstn,
  input  wire logic [7:0]       i_rd_data,
  output logic                  o_cmd_valid,
  output logic [7:0]            o_cmd_op,
  output logic [21:0]           o_cmd_addr,
  output logic                  o_wr_valid,
  output logic [7:0]            o_wr_data,
  output logic                  o_rd_req,
  output logic                  o_cmd_end
);
  typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA, ST_IGNORE} dev_state_t;

  dev_state_t                 state_ff;
  logic [5:0]                 cnt_ff;
  logic [31:0]                shift_ff;
  logic [7:0]                 op_ff;
  logic [7:0]                 data_ff;
  logic [2:0]                 dcnt_ff;
  logic [7:0]                 out_ff;
  logic                       dual_in;
  logic                       dual_out;
  logic                       cs_q_ff;
  logic [7:0]                 nxt_byte;
  logic [31:0]                nxt_shift;

  // Dual modes follow the decoded opcode once in the data phase.
  assign dual_in  = (state_ff == ST_DATA) && (op_ff == flash_cmd_pkg::OP_PROG_DUAL); // RULE4
  assign dual_out = (state_ff == ST_DATA) && (op_ff == flash_cmd_pkg::OP_READ_DUAL); // RULE5
  assign nxt_shift = {shift_ff[30:0], link.si_line}; // RULE8
  assign nxt_byte  = dual_in ? {data_ff[5:0], link.so_line, link.si_line}
                             : {data_ff[6:0], link.si_line};

  // End-of-command flag: set at once by the deselect, since the clock stops between
  // frames, and cleared at the first rising edge of the next frame. RULE9
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      cs_q_ff <= 1'b1;
    end else begin
      cs_q_ff <= 1'b0;
    end
  end

  // Sampling always happens on the rising edge, whatever the idle level. RULE1 RULE2 RULE3
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      state_ff <= ST_IDLE; // RULE9 RULE12 RULE15
      cnt_ff   <= '0;
      shift_ff <= '0;
      op_ff    <= '0;
      data_ff  <= '0;
      dcnt_ff  <= '0;
    end else begin
      case (state_ff)
        ST_IDLE, ST_OPCODE: begin // RULE6
          shift_ff <= nxt_shift;
          cnt_ff   <= 6'(cnt_ff + 6'h01);
          state_ff <= ST_OPCODE;
          if (cnt_ff == 6'(flash_cmd_pkg::OPCODE_BITS - 1)) begin // RULE7
            op_ff <= nxt_shift[7:0];
            if (!flash_cmd_pkg::op_known(nxt_shift[7:0])) begin
              state_ff <= ST_IGNORE; // RULE10
            end else if (flash_cmd_pkg::op_has_addr(nxt_shift[7:0])) begin
              state_ff <= ST_ADDR;
            end else begin
              state_ff <= ST_DATA;
            end
          end
        end
        ST_ADDR: begin
          shift_ff <= nxt_shift;
          cnt_ff   <= 6'(cnt_ff + 6'h01);
          if (cnt_ff == 6'(flash_cmd_pkg::ADDR_END - 1)) begin // RULE13
            state_ff <= ST_DATA;
          end
        end
        ST_DATA: begin
          data_ff <= nxt_byte;
          dcnt_ff <= 3'(dcnt_ff + (dual_in ? 3'h2 : 3'h1));
        end
        ST_IGNORE: state_ff <= ST_IGNORE; // RULE11
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Core strobes are one serial clock wide; they need the clock to keep running.
  always_ff @(posedge link.sck) begin
    if (!i_rstn || cs_q_ff) begin
      o_cmd_valid <= 1'b0;
      o_cmd_op    <= '0;
      o_cmd_addr  <= '0;
      o_wr_valid  <= 1'b0;
      o_wr_data   <= '0;
      o_rd_req    <= 1'b0;
    end else begin
      o_cmd_valid <= 1'b0;
      o_wr_valid  <= 1'b0;
      o_rd_req    <= 1'b0;
      if (state_ff == ST_OPCODE && cnt_ff == 6'(flash_cmd_pkg::OPCODE_BITS - 1)
          && flash_cmd_pkg::op_known(nxt_shift[7:0])
          && !flash_cmd_pkg::op_has_addr(nxt_shift[7:0])) begin
        o_cmd_valid <= 1'b1;
        o_cmd_op    <= nxt_shift[7:0];
        o_cmd_addr  <= '0;
      end
      if (state_ff == ST_ADDR && cnt_ff == 6'(flash_cmd_pkg::ADDR_END - 1)) begin
        o_cmd_valid <= 1'b1; // RULE12
        o_cmd_op    <= op_ff;
        o_cmd_addr  <= nxt_shift[flash_cmd_pkg::ARRAY_BITS-1:0]; // RULE14
      end
      if (state_ff == ST_DATA && (dcnt_ff == 3'h7 || (dual_in && dcnt_ff == 3'h6))) begin
        o_wr_valid <= 1'b1;
        o_wr_data  <= nxt_byte;
      end
      if (state_ff == ST_DATA && dcnt_ff == 3'h0) begin
        o_rd_req <= 1'b1;
      end
    end
  end

  assign o_cmd_end = cs_q_ff;

  // Output bits change on the falling edge so the host sees them settled. RULE3
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      out_ff         <= '0;
      link.dev_so_o  <= 1'b0;
      link.dev_so_oe <= 1'b0;
      link.dev_si_o  <= 1'b0;
      link.dev_si_oe <= 1'b0;
    end else if (state_ff == ST_DATA && !dual_in) begin
      if (dcnt_ff == 3'h0 || (dual_out && dcnt_ff == 3'h2)) begin
        out_ff <= dual_out ? {i_rd_data[5:0], 2'b00} : {i_rd_data[6:0], 1'b0};
        link.dev_so_o <= dual_out ? i_rd_data[6] : i_rd_data[7]; // RULE8
        link.dev_si_o <= i_rd_data[7];
      end else begin
        out_ff <= dual_out ? {out_ff[5:0], 2'b00} : {out_ff[6:0], 1'b0};
        link.dev_so_o <= dual_out ? out_ff[6] : out_ff[7];
        link.dev_si_o <= out_ff[7];
      end
      link.dev_so_oe <= 1'b1;
      link.dev_si_oe <= dual_out; // RULE5
    end else begin
      link.dev_so_oe <= 1'b0; // RULE4
      link.dev_si_oe <= 1'b0;
    end
  end
endmodule

//--- design/flash_cmd_host.sv
// Host end: a mode 0 master that sends opcode, address and bytes from its own clock.
`timescale 1ns/1ns
module flash_cmd_host #(
  parameter int DIV = 2
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Request side.
  input  wire logic        i_start,
  input  wire logic [7:0]  i_op,
  input  wire logic [23:0] i_addr,
  input  wire logic        i_with_addr,
  input  wire logic [3:0]  i_nbytes,
  input  wire logic [7:0]  i_wdata,
  output logic             o_busy,
  output logic             o_rx_valid,
  output logic [7:0]       o_rx_data,
  // Link side.
  spi_flash_if.host        link
);
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_END} host_state_t;

  host_state_t state_ff;
  logic [7:0]  div_ff;
  logic [5:0]  bits_ff;
  logic [31:0] tx_ff;
  logic [7:0]  rx_ff;
  logic [2:0]  rxc_ff;
  logic [3:0]  bytes_ff;
  logic        sck_ff;
  logic        so_sync;

  bit_sync u_so_sync (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_d    (link.so_line),
    .o_q    (so_sync)
  );

  assign link.sck        = sck_ff;
  assign link.host_so_o  = 1'b0;
  assign link.host_so_oe = 1'b0;

  // Mode 0 master: clock idles low, data moves on the falling edge, MSB first. RULE1 RULE3 RULE8
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_ff        <= H_IDLE;
      div_ff          <= '0;
      bits_ff         <= '0;
      tx_ff           <= '0;
      rx_ff           <= '0;
      rxc_ff          <= '0;
      bytes_ff        <= '0;
      sck_ff          <= 1'b0;
      link.cs_n       <= 1'b1;
      link.host_si_o  <= 1'b0;
      link.host_si_oe <= 1'b0;
      o_busy          <= 1'b0;
      o_rx_valid      <= 1'b0;
      o_rx_data       <= '0;
    end else begin
      o_rx_valid <= 1'b0;
      case (state_ff)
        H_IDLE: if (i_start) begin
          link.cs_n       <= 1'b0; // RULE6
          link.host_si_oe <= 1'b1;
          link.host_si_o  <= i_op[7]; // RULE7
          tx_ff    <= i_with_addr ? {i_op[6:0], i_addr, 1'b0} : {i_op[6:0], i_wdata, 17'h0};
          bits_ff  <= i_with_addr ? 6'(flash_cmd_pkg::ADDR_END) : 6'h08; // RULE13
          bytes_ff <= i_nbytes;
          div_ff   <= '0;
          o_busy   <= 1'b1;
          state_ff <= H_SHIFT;
        end
        H_SHIFT: begin
          div_ff <= 8'(div_ff + 8'h01);
          if (div_ff == 8'(DIV - 1)) begin
            div_ff <= '0;
            sck_ff <= !sck_ff;
            // The returned bit passes two flops, so it is taken a full link period
            // after the device launched it, at the next falling edge.
            if (sck_ff) begin
              rx_ff  <= {rx_ff[6:0], so_sync};
              rxc_ff <= 3'(rxc_ff + 3'h1);
              if (bits_ff <= 6'h08 && rxc_ff == 3'h7) begin
                o_rx_valid <= 1'b1;
                o_rx_data  <= {rx_ff[6:0], so_sync};
              end
              bits_ff <= 6'(bits_ff - 6'h01);
              link.host_si_o <= tx_ff[31];
              tx_ff <= {tx_ff[30:0], 1'b0};
              if (bits_ff == 6'h01) begin
                if (bytes_ff == 4'h0) begin
                  state_ff <= H_END;
                end else begin
                  bytes_ff <= 4'(bytes_ff - 4'h1);
                  bits_ff  <= 6'h08;
                  link.host_si_o <= i_wdata[7];
                  tx_ff    <= {i_wdata[6:0], 25'h0};
                end
              end
            end
          end
        end
        H_END: begin
          link.cs_n       <= 1'b1; // RULE9
          link.host_si_oe <= 1'b0;
          rxc_ff          <= '0;
          o_busy          <= 1'b0;
          state_ff        <= H_IDLE;
        end
        default: state_ff <= H_IDLE;
      endcase
    end
  end
endmodule

//--- design/flash_cmd_pkg.sv
// Shared constants for the serial flash command front end and its host end.
package flash_cmd_pkg;
  localparam int OPCODE_BITS = 8;
  localparam int ADDR_BITS   = 24;
  localparam int ARRAY_BITS  = 22;
  localparam int DATA_BITS   = 8;
  localparam int CNT_BITS    = 6;
  localparam int ADDR_END    = OPCODE_BITS + ADDR_BITS;
  localparam logic [7:0] OP_READ_SLOW  = 8'h03;
  localparam logic [7:0] OP_READ_FAST  = 8'h0B;
  localparam logic [7:0] OP_READ_MAX   = 8'h1B;
  localparam logic [7:0] OP_READ_DUAL  = 8'h3B;
  localparam logic [7:0] OP_PROG       = 8'h02;
  localparam logic [7:0] OP_PROG_DUAL  = 8'hA2;
  localparam logic [7:0] OP_ERASE_4K   = 8'h20;
  localparam logic [7:0] OP_ERASE_32K  = 8'h52;
  localparam logic [7:0] OP_ERASE_64K  = 8'hD8;
  localparam logic [7:0] OP_PROT       = 8'h36;
  localparam logic [7:0] OP_UNPROT     = 8'h39;
  localparam logic [7:0] OP_RD_PROT    = 8'h3C;
  localparam logic [7:0] OP_LOCKDOWN   = 8'h33;
  localparam logic [7:0] OP_FREEZE     = 8'h34;
  localparam logic [7:0] OP_RD_LOCK    = 8'h35;
  localparam logic [7:0] OP_OTP_PROG   = 8'h9B;
  localparam logic [7:0] OP_OTP_READ   = 8'h77;
  localparam logic [7:0] OP_CHIP_ER_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ER_B  = 8'hC7;
  localparam logic [7:0] OP_SUSPEND    = 8'hB0;
  localparam logic [7:0] OP_RESUME     = 8'hD0;
  localparam logic [7:0] OP_WR_EN      = 8'h06;
  localparam logic [7:0] OP_WR_DIS     = 8'h04;
  localparam logic [7:0] OP_RD_STATUS  = 8'h05;
  localparam logic [7:0] OP_WR_STAT1   = 8'h01;
  localparam logic [7:0] OP_WR_STAT2   = 8'h31;
  localparam logic [7:0] OP_RESET      = 8'hF0;
  localparam logic [7:0] OP_READ_ID    = 8'h9F;
  localparam logic [7:0] OP_DEEP_PD    = 8'hB9;
  localparam logic [7:0] OP_WAKE       = 8'hAB;

  // Opcodes followed by three address bytes.
  function automatic logic op_has_addr(input logic [7:0] op);
    case (op)
      OP_READ_SLOW, OP_READ_FAST, OP_READ_MAX, OP_READ_DUAL, OP_PROG, OP_PROG_DUAL,
      OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_PROT, OP_UNPROT, OP_RD_PROT,
      OP_LOCKDOWN, OP_FREEZE, OP_RD_LOCK, OP_OTP_PROG, OP_OTP_READ: op_has_addr = 1'b1;
      default: op_has_addr = 1'b0;
    endcase
  endfunction

  // Every opcode the device accepts.
  function automatic logic op_known(input logic [7:0] op);
    case (op)
      OP_CHIP_ER_A, OP_CHIP_ER_B, OP_SUSPEND, OP_RESUME, OP_WR_EN, OP_WR_DIS,
      OP_RD_STATUS, OP_WR_STAT1, OP_WR_STAT2, OP_RESET, OP_READ_ID, OP_DEEP_PD,
      OP_WAKE: op_known = 1'b1;
      default: op_known = op_has_addr(op);
    endcase
  endfunction
endpackage

//--- design/spi_flash_if.sv
// Four-wire flash link with dual-use data pins, one modport per end.
`timescale 1ns/1ns
interface spi_flash_if;
  logic sck;
  logic cs_n;
  logic host_si_o;
  logic host_si_oe;
  logic dev_si_o;
  logic dev_si_oe;
  logic host_so_o;
  logic host_so_oe;
  logic dev_so_o;
  logic dev_so_oe;
  logic si_line;
  logic so_line;

  // Wire levels resolved from the enables; an undriven line floats low.
  assign si_line = host_si_oe ? host_si_o : (dev_si_oe ? dev_si_o : 1'b0);
  assign so_line = dev_so_oe ? dev_so_o : (host_so_oe ? host_so_o : 1'b0);

  modport device (input sck, input cs_n, input si_line, input so_line,
                  output dev_si_o, output dev_si_oe, output dev_so_o, output dev_so_oe);
  modport host (output sck, output cs_n, input si_line, input so_line,
                output host_si_o, output host_si_oe, output host_so_o, output host_so_oe);
endinterface

//--- verif/flash_link_chk.sv
// Link-level checks on the flash serial link, sampled on the host clock.
`timescale 1ns/1ns
module flash_link_chk (
  // Clock and reset of the host domain.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Link signals.
  input wire logic sck,
  input wire logic cs_n,
  input wire logic host_si_o,
  input wire logic host_si_oe,
  input wire logic host_so_oe,
  input wire logic dev_si_oe,
  input wire logic dev_so_o,
  input wire logic dev_so_oe
);
  logic [7:0] nbits_ff;
  logic       sck_q_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // Rising clock edges in the current frame; cleared while deselected so each frame counts alone.
  always_ff @(posedge i_clk) begin
    if (!i_rstn || cs_n) begin
      nbits_ff <= 8'h00;
    end else if (sck && !sck_q_ff) begin
      nbits_ff <= nbits_ff + 8'h01;
    end
  end

  // Previous clock level for edge detection.
  always_ff @(posedge i_clk) begin
    sck_q_ff <= sck;
  end

  AST_IDLE_CLOCK_LOW: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("serial clock not idle low while deselected");
  AST_SELECT_BEFORE_CLOCK: assert property ($fell(cs_n) |-> !sck && !$past(sck))
    else $error("clock moved before chip select asserted");
  AST_WHOLE_BYTES: assert property ($rose(cs_n) |-> nbits_ff[2:0] == 3'h0 && nbits_ff >= 8'h08)
    else $error("frame did not carry whole bytes after an opcode");
  AST_SO_IDLE: assert property (cs_n |-> !dev_so_oe)
    else $error("device drives output line while deselected");
  AST_SI_IDLE: assert property (cs_n |-> !dev_si_oe)
    else $error("device drives input line while deselected");
  AST_SO_ONE_DRIVER: assert property (!(dev_so_oe && host_so_oe))
    else $error("both ends drive the output line");
  AST_SI_ONE_DRIVER: assert property (!(dev_si_oe && host_si_oe))
    else $error("both ends drive the input line");
  AST_DEV_OUT_ON_FALL: assert property (
    dev_so_oe && $past(dev_so_oe) && $changed(dev_so_o) |-> $fell(sck))
    else $error("device output changed away from a falling clock edge");
  AST_HOST_HOLD_AT_RISE: assert property ($rose(sck) |-> $stable(host_si_o))
    else $error("host data moved on a rising clock edge");

  // Main frame shapes: read, write and truncated frames, then the device driving its output line while selected.
  cover property ($rose(cs_n) && nbits_ff == 8'h28);
  cover property ($rose(cs_n) && nbits_ff == 8'h30);
  cover property ($rose(cs_n) && nbits_ff == 8'h18);
  cover property (dev_so_oe && !cs_n);
endmodule

//--- verif/test_serial_flash_command_frontend.sv
// Self-checking bench: host and device ends joined over one link.
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] t=%0t got %0h expected %0h", $time, (got), (exp)); end end
module test_serial_flash_command_frontend;
  logic        i_clk;
  logic        i_rstn;
  logic        h_start;
  logic [7:0]  h_op;
  logic [23:0] h_addr;
  logic        h_with_addr;
  logic [3:0]  h_nbytes;
  logic [7:0]  h_wdata;
  logic        h_busy;
  logic        h_rx_valid;
  logic [7:0]  h_rx_data;
  logic [7:0]  d_rd_data;
  logic        d_cmd_valid;
  logic [7:0]  d_cmd_op;
  logic [21:0] d_cmd_addr;
  logic        d_wr_valid;
  logic [7:0]  d_wr_data;
  logic        d_rd_req;
  logic        d_cmd_end;
  int          mismatches = 0;
  int          compares = 0;
  int          n_cmd = 0;
  int          n_wr = 0;
  int          n_rd = 0;
  logic [7:0]  rx_last;
  logic [7:0]  op_seen;
  logic [21:0] addr_seen;
  logic [7:0]  wr_seen;

  spi_flash_if link ();

  flash_cmd_host #(.DIV(2)) flash_cmd_host_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_start(h_start), .i_op(h_op), .i_addr(h_addr),
    .i_with_addr(h_with_addr), .i_nbytes(h_nbytes), .i_wdata(h_wdata), .o_busy(h_busy),
    .o_rx_valid(h_rx_valid), .o_rx_data(h_rx_data), .link(link));

  flash_cmd_device flash_cmd_device_inst (
    .link(link), .i_rstn(i_rstn), .i_rd_data(d_rd_data), .o_cmd_valid(d_cmd_valid),
    .o_cmd_op(d_cmd_op), .o_cmd_addr(d_cmd_addr), .o_wr_valid(d_wr_valid),
    .o_wr_data(d_wr_data), .o_rd_req(d_rd_req), .o_cmd_end(d_cmd_end));

  flash_link_chk flash_link_chk_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .sck(link.sck), .cs_n(link.cs_n),
    .host_si_o(link.host_si_o), .host_si_oe(link.host_si_oe), .host_so_oe(link.host_so_oe),
    .dev_si_oe(link.dev_si_oe), .dev_so_o(link.dev_so_o), .dev_so_oe(link.dev_so_oe));

  // Host clock of 10 ns; the link clock is divided from it by the host.
  always #5 i_clk = ~i_clk;

  // Device strobes are counted on their rising edge; the small wait lets the data settle.
  always @(posedge d_cmd_valid) begin
    #1;
    n_cmd++;
    op_seen = d_cmd_op;
    addr_seen = d_cmd_addr;
  end
  always @(posedge d_wr_valid) begin
    #1;
    n_wr++;
    wr_seen = d_wr_data;
  end
  always @(posedge d_rd_req) n_rd++;
  always @(posedge i_clk) if (h_rx_valid === 1'b1) rx_last <= h_rx_data;

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One whole frame from the host; waits for busy to drop under a bounded count.
  task automatic run_frame(input logic [7:0] op, input logic [23:0] addr,
                           input logic wa, input logic [3:0] nb);
    int n;
    n = 0;
    @(posedge i_clk); #1;
    h_op = op;
    h_addr = addr;
    h_with_addr = wa;
    h_nbytes = nb;
    h_start = 1'b1;
    @(posedge i_clk); #1;
    h_start = 1'b0;
    while (link.cs_n !== 1'b0 && n < 50) begin @(posedge i_clk); n++; end
    @(posedge link.sck);
    `CHK(link.si_line, op[7])
    while (h_busy !== 1'b0 && n < 3000) begin @(posedge i_clk); n++; end
    if (n >= 3000) `CHK(h_busy, 1'b0)
    repeat (6) @(posedge i_clk);
  endtask

  // Program frame with the top address bits set and two data bytes.
  task automatic t_write();
    int c, w;
    c = n_cmd;
    w = n_wr;
    h_wdata = 8'hA5;
    run_frame(8'h02, 24'hC12345, 1'b1, 4'h2);
    `CHK(n_cmd - c, 1)
    `CHK(op_seen, 8'h02)
    `CHK(addr_seen, 22'h012345)
    `CHK(n_wr - w, 2)
    `CHK(wr_seen, 8'hA5)
    `CHK(d_cmd_end, 1'b1)
    $display("write frame done");
  endtask

  // Read frame at the top of the array; the device answers on the output line.
  task automatic t_read();
    int r;
    r = n_rd;
    d_rd_data = 8'h96;
    run_frame(8'h03, 24'h3FFFFF, 1'b1, 4'h1);
    `CHK(addr_seen, 22'h3FFFFF)
    `CHK(n_rd - r, 1)
    `CHK(rx_last, 8'h96)
    $display("read frame done");
  endtask

  // Unsupported opcode with trailing bytes, then a valid frame after reselection.
  task automatic t_bad();
    int c, w, r;
    c = n_cmd;
    w = n_wr;
    r = n_rd;
    run_frame(8'hFF, 24'h123456, 1'b1, 4'h2);
    `CHK(n_cmd - c, 0)
    `CHK(n_wr - w, 0)
    `CHK(n_rd - r, 0)
    run_frame(8'h05, 24'h000000, 1'b0, 4'h1);
    `CHK(n_cmd - c, 1)
    `CHK(op_seen, 8'h05)
    $display("unsupported opcode done");
  endtask

  // Address opcode cut off after two bytes of address.
  task automatic t_short();
    int c, w;
    c = n_cmd;
    w = n_wr;
    run_frame(8'h02, 24'h000000, 1'b0, 4'h2);
    `CHK(n_cmd - c, 0)
    `CHK(n_wr - w, 0)
    run_frame(8'h05, 24'h000000, 1'b0, 4'h1);
    `CHK(n_cmd - c, 1)
    $display("truncated frame done");
  endtask

  // Main sequence: reset for 16 cycles, then each scenario in turn.
  initial begin
    i_clk = 1'b0;
    i_rstn = 1'b0;
    h_start = 1'b0;
    h_op = 8'h00;
    h_addr = 24'h000000;
    h_with_addr = 1'b0;
    h_nbytes = 4'h0;
    h_wdata = 8'h00;
    d_rd_data = 8'h00;
    repeat (16) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    t_write();
    t_read();
    t_bad();
    t_short();
    wrap_up();
  end

  // Watchdog: the frames need under a thousand cycles, so this span is ample.
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    wrap_up();
  end
endmodule
